// ===== dcom_params.svh
// Constants for the drive command object map
`ifndef DCOM_PARAMS_SVH
`define DCOM_PARAMS_SVH
// ==========================================
// Object indices
`define DCOM_IDX_RUN 16'h2000
`define DCOM_IDX_SPD 16'h2010
`define DCOM_IDX_TRQ 16'h2020
`define DCOM_IDX_TCMP 16'h2030
`define DCOM_IDX_RDREQ 16'h2040
`define DCOM_IDX_WRREQ 16'h2050
`define DCOM_IDX_RDRSP 16'h2140
`define DCOM_IDX_WRRSP 16'h2150
// ==========================================
// Drive register addresses
`define DCOM_REG_RUN 16'h0001
`define DCOM_REG_SPD 16'h0002
`define DCOM_REG_TRQ 16'h0004
`define DCOM_REG_TCMP 16'h0005
// ==========================================
// Field positions and values
`define DCOM_BIT_FWD 0
`define DCOM_BIT_REV 1
`define DCOM_BIT_TERM_LO 2
`define DCOM_BIT_FAULT 8
`define DCOM_BIT_RESET 9
`define DCOM_RUN_SRC_NET 2'h3
`define DCOM_CTRL_SPEED 1'h0
`define DCOM_TRQ_SRC_NET 2'h1
`define DCOM_RESET_WORD 16'h0000
// ==========================================
// Timing at 10 MHz
`define DCOM_CLK_HZ 10000000
`define DCOM_IN_CYCLE_US 2000
`define DCOM_OUT_SLOW_US 8000
`define DCOM_IN_TICKS (`DCOM_CLK_HZ / 1000000 * `DCOM_IN_CYCLE_US)
`define DCOM_SLOW_DIV (`DCOM_OUT_SLOW_US / `DCOM_IN_CYCLE_US)
`endif

// ===== dcom_pkg.sv
// Types for the drive command object map
package dcom_pkg;
    typedef enum logic [3:0] {
        DCOM_IDLE = 4'h1,
        DCOM_ISSUE = 4'h2,
        DCOM_WAIT = 4'h4,
        DCOM_DONE = 4'h8
    } dcom_state_t;
    typedef enum logic [1:0] {
        DCOM_UNIT_HZ = 2'h0,
        DCOM_UNIT_PCT = 2'h1,
        DCOM_UNIT_RPM = 2'h2,
        DCOM_UNIT_USER = 2'h3
    } dcom_unit_t;
endpackage

// ===== dcom_tick.sv
// Processing cycle tick generator
`timescale 1ns/1ps
`include "dcom_params.svh"
module dcom_tick #(
    parameter int unsigned TICKS = `DCOM_IN_TICKS
) (
    input wire logic sys_clk, // System clock
    input wire logic resetn, // Sync reset, active low
    input wire logic clk_en, // Clock enable
    output logic tick_fast, // 2 ms pulse
    output logic tick_slow // 8 ms pulse
);
    typedef struct packed {
        logic [31:0] cnt;
        logic [1:0] div;
    } dcom_tick_st_t;
    dcom_tick_st_t st_ff, nxt_st;
    // Count down one processing cycle; every fourth is slow
    always_comb begin
        nxt_st = st_ff;
        if (st_ff.cnt == 32'h0) begin
            nxt_st.cnt = TICKS - 1;
            nxt_st.div = 2'(st_ff.div + 2'h1);
        end else begin
            nxt_st.cnt = st_ff.cnt - 32'h1;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            st_ff <= '0;
        end else if (clk_en) begin
            st_ff <= nxt_st;
        end
    end
    assign tick_fast = clk_en && (st_ff.cnt == 32'h0);
    assign tick_slow = tick_fast && (st_ff.div == 2'(`DCOM_SLOW_DIV - 1));
endmodule

// ===== dcom_core.sv
// Drive command object map: object decode and drive register access
`timescale 1ns/1ps
`include "dcom_params.svh"
module dcom_core #(
    parameter int unsigned TICKS = `DCOM_IN_TICKS
) (
    input wire logic sys_clk, // System clock
    input wire logic resetn, // Sync reset, active low
    input wire logic clk_en, // Clock enable
    // Object access from the master
    input wire logic obj_wr, // Object write strobe
    input wire logic obj_rd, // Object read strobe
    input wire logic [15:0] obj_index, // Object index
    input wire logic [7:0] obj_sub, // Subindex
    input wire logic [31:0] obj_wdata, // Write data
    output logic [31:0] obj_rdata, // Read data
    output logic obj_ack, // Access answered
    output logic obj_err, // Unknown object, or write to a response object
    // Drive settings
    input wire logic [1:0] run_command_source, // Run source
    input wire logic control_selection, // 0 speed, 1 torque
    input wire logic [1:0] speed_display_unit, // Speed unit
    input wire logic [1:0] torque_reference_source, // Torque source
    // Decoded drive controls
    output logic run_forward, // Forward run request
    output logic run_reverse, // Reverse run request
    output logic [5:0] input_terminal, // Virtual terminals 3..8
    output logic network_external_fault, // External fault
    output logic fault_reset, // Fault reset
    output logic [15:0] speed_reference, // Speed reference
    output logic [15:0] speed_limit, // Speed limit
    output logic [1:0] speed_unit, // Unit of speed values
    output logic [15:0] torque_reference, // Torque reference
    output logic [15:0] torque_limit, // Torque limit
    output logic torque_valid, // Torque object in use
    output logic [15:0] torque_compensation_out, // Torque compensation
    output logic tick_slow, // Slow output update strobe
    // Drive register interface
    output logic drv_req, // Register request
    output logic drv_we, // Write when high
    output logic [15:0] drive_register_address, // Register address
    output logic [15:0] drv_wdata, // Register write data
    input wire logic drv_ack, // Register answer
    input wire logic [15:0] drv_rdata // Register read data
);
    // ==========================================
    // State
    typedef struct packed {
        dcom_pkg::dcom_state_t fsm;
        logic [15:0] run_cmd;
        logic [15:0] spd;
        logic [15:0] trq;
        logic [15:0] tcmp;
        logic [31:0] rd_req;
        logic [31:0] wr_req;
        logic rd_pend;
        logic wr_pend;
        logic cur_we;
        logic [2:0] slot;
        logic [31:0] rd_rsp;
        logic [31:0] wr_rsp;
        logic [31:0] rdata;
        logic ack;
        logic err;
        logic [15:0] o_run;
        logic [15:0] o_spd;
        logic [15:0] o_trq;
        logic [15:0] o_tcmp;
        logic req;
        logic we;
        logic [15:0] addr;
        logic [15:0] wdata;
    } dcom_st_t;
    dcom_st_t st_ff, nxt_st;
    logic tick_fast;
    logic run_ok;
    logic trq_ok;
    // ==========================================
    // Processing cycle
    dcom_tick #(
        .TICKS(TICKS)
    ) u_tick (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .tick_fast(tick_fast),
        .tick_slow(tick_slow)
    );
    // Decode an object read
    function automatic logic [32:0] rd_obj(input dcom_st_t s,
            input logic [15:0] idx, input logic [7:0] sub);
        logic [32:0] r;
        r = {1'b0, 32'h0};
        case (idx)
            `DCOM_IDX_RUN: begin
                if (sub == 8'h2) begin
                    r[31:0] = {16'h0, `DCOM_REG_RUN};
                end else begin
                    r[31:0] = {16'h0, s.run_cmd};
                end
            end
            `DCOM_IDX_SPD: begin
                if (sub == 8'h2) begin
                    r[31:0] = {16'h0, `DCOM_REG_SPD};
                end else begin
                    r[31:0] = {16'h0, s.spd};
                end
            end
            `DCOM_IDX_TRQ: begin
                if (sub == 8'h2) begin
                    r[31:0] = {16'h0, `DCOM_REG_TRQ};
                end else begin
                    r[31:0] = {16'h0, s.trq};
                end
            end
            `DCOM_IDX_TCMP: begin
                if (sub == 8'h2) begin
                    r[31:0] = {16'h0, `DCOM_REG_TCMP};
                end else begin
                    r[31:0] = {16'h0, s.tcmp};
                end
            end
            `DCOM_IDX_RDREQ: begin
                r[31:0] = (sub == 8'h0) ? 32'h1 : s.rd_req;
            end
            `DCOM_IDX_WRREQ: begin
                r[31:0] = (sub == 8'h0) ? 32'h1 : s.wr_req;
            end
            `DCOM_IDX_RDRSP: begin
                r[31:0] = s.rd_rsp;
            end
            `DCOM_IDX_WRRSP: begin
                r[31:0] = s.wr_rsp;
            end
            default: begin
                r[32] = 1'b1;
            end
        endcase
        return r;
    endfunction
    // ==========================================
    // Next state
    always_comb begin
        logic [32:0] rr;
        logic wr_known;
        rr = rd_obj(st_ff, obj_index, obj_sub);
        wr_known = 1'b0;
        nxt_st = st_ff;
        nxt_st.ack = 1'b0;
        nxt_st.err = 1'b0;
        // Object writes; address subindexes stay read-only
        if (obj_wr) begin
            wr_known = 1'b1;
            case (obj_index)
                `DCOM_IDX_RUN: begin
                    if (obj_sub != 8'h2) begin
                        nxt_st.run_cmd = obj_wdata[15:0];
                    end
                end
                `DCOM_IDX_SPD: begin
                    if (obj_sub != 8'h2) begin
                        nxt_st.spd = obj_wdata[15:0];
                    end
                end
                `DCOM_IDX_TRQ: begin
                    if (obj_sub != 8'h2) begin
                        nxt_st.trq = obj_wdata[15:0];
                    end
                end
                `DCOM_IDX_TCMP: begin
                    if (obj_sub != 8'h2) begin
                        nxt_st.tcmp = obj_wdata[15:0];
                    end
                end
                `DCOM_IDX_RDREQ: begin
                    nxt_st.rd_req = obj_wdata;
                    nxt_st.rd_pend = 1'b1;
                end
                `DCOM_IDX_WRREQ: begin
                    nxt_st.wr_req = obj_wdata;
                    nxt_st.wr_pend = 1'b1;
                end
                default: begin
                    wr_known = 1'b0;
                end
            endcase
            nxt_st.ack = 1'b1;
            nxt_st.err = !wr_known;
        end else if (obj_rd) begin
            nxt_st.rdata = rr[31:0];
            nxt_st.ack = 1'b1;
            nxt_st.err = rr[32];
        end
        // Snapshot inputs once per processing cycle
        if (tick_fast) begin
            nxt_st.o_run = st_ff.run_cmd;
            nxt_st.o_spd = st_ff.spd;
            nxt_st.o_trq = st_ff.trq;
            nxt_st.o_tcmp = st_ff.tcmp;
        end
        // Drive register sequencer, one transfer at a time
        case (st_ff.fsm)
            dcom_pkg::DCOM_IDLE: begin
                if (tick_fast) begin
                    nxt_st.slot = 3'h0;
                    nxt_st.fsm = dcom_pkg::DCOM_ISSUE;
                end
            end
            dcom_pkg::DCOM_ISSUE: begin
                nxt_st.req = 1'b1;
                nxt_st.we = 1'b1;
                nxt_st.cur_we = 1'b1;
                nxt_st.fsm = dcom_pkg::DCOM_WAIT;
                case (st_ff.slot)
                    3'h0: begin
                        nxt_st.addr = `DCOM_REG_RUN;
                        nxt_st.wdata = st_ff.o_run;
                    end
                    3'h1: begin
                        nxt_st.addr = `DCOM_REG_SPD;
                        nxt_st.wdata = st_ff.o_spd;
                    end
                    3'h2: begin
                        nxt_st.addr = `DCOM_REG_TRQ;
                        nxt_st.wdata = st_ff.o_trq;
                    end
                    3'h3: begin
                        nxt_st.addr = `DCOM_REG_TCMP;
                        nxt_st.wdata = st_ff.o_tcmp;
                    end
                    3'h4: begin
                        nxt_st.we = 1'b0;
                        nxt_st.cur_we = 1'b0;
                        nxt_st.addr = st_ff.rd_req[31:16];
                        nxt_st.wdata = 16'h0;
                        nxt_st.req = st_ff.rd_pend;
                        if (!st_ff.rd_pend) begin
                            nxt_st.fsm = dcom_pkg::DCOM_DONE;
                        end
                    end
                    default: begin
                        nxt_st.addr = st_ff.wr_req[31:16];
                        nxt_st.wdata = st_ff.wr_req[15:0];
                        nxt_st.req = st_ff.wr_pend;
                        if (!st_ff.wr_pend) begin
                            nxt_st.fsm = dcom_pkg::DCOM_DONE;
                        end
                    end
                endcase
            end
            dcom_pkg::DCOM_WAIT: begin
                if (drv_ack) begin
                    nxt_st.req = 1'b0;
                    nxt_st.fsm = dcom_pkg::DCOM_DONE;
                    if (st_ff.slot == 3'h4) begin
                        nxt_st.rd_rsp = {16'h0, drv_rdata};
                        nxt_st.rd_pend = 1'b0;
                    end else if (st_ff.slot == 3'h5) begin
                        nxt_st.wr_rsp = st_ff.wr_req;
                        nxt_st.wr_pend = 1'b0;
                    end
                end
            end
            dcom_pkg::DCOM_DONE: begin
                nxt_st.req = 1'b0;
                if (st_ff.slot == 3'h5) begin
                    nxt_st.fsm = dcom_pkg::DCOM_IDLE;
                end else begin
                    nxt_st.slot = 3'(st_ff.slot + 3'h1);
                    nxt_st.fsm = dcom_pkg::DCOM_ISSUE;
                end
            end
            default: begin
                nxt_st.fsm = dcom_pkg::DCOM_IDLE;
            end
        endcase
        // New request arriving as the old one completes is kept
        if (obj_wr && obj_index == `DCOM_IDX_RDREQ) begin
            nxt_st.rd_pend = 1'b1;
        end
        if (obj_wr && obj_index == `DCOM_IDX_WRREQ) begin
            nxt_st.wr_pend = 1'b1;
        end
    end
    // ==========================================
    // Registers
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            st_ff <= '0;
            st_ff.fsm <= dcom_pkg::DCOM_IDLE;
            st_ff.run_cmd <= `DCOM_RESET_WORD;
        end else if (clk_en) begin
            st_ff <= nxt_st;
        end
    end
    // ==========================================
    // Decoded controls from the latched snapshot
    assign run_ok = (run_command_source == `DCOM_RUN_SRC_NET);
    assign trq_ok = (torque_reference_source == `DCOM_TRQ_SRC_NET);
    assign run_forward = run_ok && st_ff.o_run[`DCOM_BIT_FWD];
    assign run_reverse = run_ok && st_ff.o_run[`DCOM_BIT_REV];
    // Bits 10..15 are never looked at
    assign input_terminal = st_ff.o_run[`DCOM_BIT_TERM_LO +: 6];
    assign network_external_fault = st_ff.o_run[`DCOM_BIT_FAULT];
    assign fault_reset = st_ff.o_run[`DCOM_BIT_RESET];
    // Speed role set by control selection
    assign speed_reference = (control_selection == `DCOM_CTRL_SPEED) ?
        st_ff.o_spd : 16'h0;
    assign speed_limit = (control_selection == `DCOM_CTRL_SPEED) ?
        16'h0 : st_ff.o_spd;
    assign speed_unit = speed_display_unit;
    // Torque in 0.1 percent, swapped role versus speed
    assign torque_valid = trq_ok;
    assign torque_reference = (trq_ok && control_selection) ?
        st_ff.o_trq : 16'h0;
    assign torque_limit = (trq_ok && !control_selection) ?
        st_ff.o_trq : 16'h0;
    assign torque_compensation_out = st_ff.o_tcmp;
    assign obj_rdata = st_ff.rdata;
    assign obj_ack = st_ff.ack;
    assign obj_err = st_ff.err;
    assign drv_req = st_ff.req;
    assign drv_we = st_ff.we;
    assign drive_register_address = st_ff.addr;
    assign drv_wdata = st_ff.wdata;
endmodule

// ===== dcom_core_checker.sv
// Port assertions for the drive command object map
`timescale 1ns/1ps
module dcom_core_checker #(
    parameter int unsigned TICKS = 20
) (
    input wire logic sys_clk, // Clock
    input wire logic resetn, // Sync reset
    input wire logic clk_en, // Clock enable
    input wire logic obj_wr, // Write strobe
    input wire logic obj_rd, // Read strobe
    input wire logic obj_ack, // Answer
    input wire logic [1:0] run_command_source, // Run source
    input wire logic run_forward, // Forward
    input wire logic run_reverse, // Reverse
    input wire logic control_selection, // Control mode
    input wire logic [15:0] speed_reference, // Speed ref
    input wire logic [15:0] speed_limit, // Speed limit
    input wire logic [1:0] speed_display_unit, // Unit setting
    input wire logic [1:0] speed_unit, // Unit out
    input wire logic [1:0] torque_reference_source, // Torque source
    input wire logic torque_valid, // Torque used
    input wire logic [15:0] torque_reference, // Torque ref
    input wire logic [15:0] torque_limit, // Torque limit
    input wire logic tick_slow, // Slow strobe
    input wire logic drv_req, // Drive request
    input wire logic drv_we, // Drive write
    input wire logic [15:0] drive_register_address, // Drive address
    input wire logic [15:0] drv_wdata, // Drive data
    input wire logic drv_ack // Drive answer
);
    typedef struct packed {
        logic [31:0] gap;
        logic seen;
    } dcom_gap_t;
    localparam int SLOW = 4 * TICKS;
    dcom_gap_t gap_ff;
    dcom_gap_t nxt_gap;
    // ==========================================
    // Slow strobe spacing; frozen cycles do not count
    always_comb begin
        nxt_gap = gap_ff;
        if (clk_en) begin
            nxt_gap.gap = gap_ff.gap + 32'h0000_0001;
        end
        if (tick_slow) begin
            nxt_gap.gap = 32'h0000_0000;
            nxt_gap.seen = 1'b1;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            gap_ff <= '0;
        end else begin
            gap_ff <= nxt_gap;
        end
    end
    // ==========================================
    // Assertions
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    ack_after_a: assert property (
        clk_en && (obj_wr || obj_rd) |=> obj_ack)
        else $error("object access not answered");
    fwd_gate_a: assert property (
        run_forward |-> run_command_source == 2'h3)
        else $error("forward run without network source");
    rev_gate_a: assert property (
        run_reverse |-> run_command_source == 2'h3)
        else $error("reverse run without network source");
    speed_role_a: assert property (
        control_selection |-> speed_reference == 16'h0000)
        else $error("speed reference in torque control");
    speed_lim_a: assert property (
        !control_selection |-> speed_limit == 16'h0000)
        else $error("speed limit in speed control");
    unit_follow_a: assert property (
        speed_unit == speed_display_unit)
        else $error("speed unit differs from setting");
    torque_use_a: assert property (
        torque_valid == (torque_reference_source == 2'h1))
        else $error("torque use flag wrong");
    torque_ref_a: assert property (
        torque_reference != 16'h0000 |-> control_selection && torque_valid)
        else $error("torque reference in wrong mode");
    torque_lim_a: assert property (
        control_selection |-> torque_limit == 16'h0000)
        else $error("torque limit in torque control");
    req_hold_a: assert property (
        drv_req && !drv_ack |=> drv_req && $stable(drive_register_address)
        && $stable(drv_we) && $stable(drv_wdata))
        else $error("drive request changed before answer");
    req_drop_a: assert property (
        drv_req && drv_ack |=> !drv_req)
        else $error("drive request held after answer");
    slow_period_a: assert property (
        tick_slow && gap_ff.seen |-> gap_ff.gap == 32'(SLOW - 1))
        else $error("slow update period wrong");
endmodule

bind dcom_core dcom_core_checker #(.TICKS(TICKS)) u_dcom_core_checker (
    .sys_clk, .resetn, .clk_en, .obj_wr, .obj_rd, .obj_ack,
    .run_command_source, .run_forward, .run_reverse, .control_selection,
    .speed_reference, .speed_limit, .speed_display_unit, .speed_unit,
    .torque_reference_source, .torque_valid, .torque_reference,
    .torque_limit, .tick_slow, .drv_req, .drv_we, .drive_register_address,
    .drv_wdata, .drv_ack);

// ===== dcom_drive_model.sv
// Behavioural drive register space answering the block's requests
`timescale 1ns/1ps
module dcom_drive_model (
    input wire logic sys_clk, // Clock
    input wire logic [3:0] ack_delay, // Answer latency
    input wire logic drv_req, // Request
    input wire logic drv_we, // Write when high
    input wire logic [15:0] drive_register_address, // Address
    input wire logic [15:0] drv_wdata, // Write data
    output logic drv_ack, // Answer pulse
    output logic [15:0] drv_rdata // Read data
);
    logic [15:0] mem [0:255];
    int wait_cnt;
    // Known pattern so read results can be predicted
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 16'h5a00 | 16'(i);
        end
        drv_ack = 1'b0;
        drv_rdata = 16'h0000;
        wait_cnt = 0;
    end
    // Data toggles outside the answer so stale reads never match
    always @(posedge sys_clk) begin
        drv_ack <= 1'b0;
        drv_rdata <= ~drv_rdata;
        if (drv_req && !drv_ack) begin
            if (wait_cnt >= int'(ack_delay)) begin
                drv_ack <= 1'b1;
                wait_cnt <= 0;
                if (drv_we) begin
                    mem[drive_register_address[7:0]] <= drv_wdata;
                end else begin
                    drv_rdata <= mem[drive_register_address[7:0]];
                end
            end else begin
                wait_cnt <= wait_cnt + 1;
            end
        end
    end
endmodule

// ===== dcom_core_test.sv
// Self-checking testbench for the drive command object map
`timescale 1ns/1ps
module dcom_core_test;
    localparam int TK = 20;
    localparam logic [15:0] IDX [4] =
        '{16'h2000, 16'h2010, 16'h2020, 16'h2030};
    localparam logic [15:0] RA [4] =
        '{16'h0001, 16'h0002, 16'h0004, 16'h0005};
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic clk_en = 1'b1;
    logic obj_wr = 1'b0;
    logic obj_rd = 1'b0;
    logic [15:0] obj_index = 16'h0000;
    logic [7:0] obj_sub = 8'h00;
    logic [31:0] obj_wdata = 32'h0000_0000;
    logic [1:0] run_command_source = 2'h0;
    logic control_selection = 1'b0;
    logic [1:0] speed_display_unit = 2'h0;
    logic [1:0] torque_reference_source = 2'h0;
    logic [3:0] ack_delay = 4'h0;
    logic [31:0] obj_rdata;
    logic obj_ack, obj_err, run_forward, run_reverse, fault_reset;
    logic network_external_fault, torque_valid, tick_slow;
    logic [5:0] input_terminal;
    logic [15:0] speed_reference, speed_limit, torque_reference;
    logic [15:0] torque_limit, torque_compensation_out;
    logic [1:0] speed_unit;
    logic drv_req, drv_we, drv_ack;
    logic [15:0] drive_register_address, drv_wdata, drv_rdata;
    logic ack_seen = 1'b0;
    logic err_seen = 1'b0;
    int fails = 0;
    int n_checks = 0;
    // ==========================================
    // Clock, design and drive model
    always #50 sys_clk = ~sys_clk;
    dcom_core #(.TICKS(TK)) u_dcom_core (.*);
    dcom_drive_model u_dcom_drive_model (.*);
    // ==========================================
    // Shared tasks
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // One object access; ack and err stand one cycle, so catch them then
    task acc(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
             input logic [31:0] wd);
        @(posedge sys_clk);
        #1;
        obj_wr = wr;
        obj_rd = !wr;
        obj_index = idx;
        obj_sub = sub;
        obj_wdata = wd;
        @(posedge sys_clk);
        #1;
        ack_seen = obj_ack;
        err_seen = obj_err;
        obj_wr = 1'b0;
        obj_rd = 1'b0;
        @(posedge sys_clk);
        #1;
    endtask
    task wait_cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task summarize;
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ==========================================
    // Scenarios
    task t_addr;
        check(32'(run_forward), 32'h0);
        for (int i = 0; i < 4; i++) begin
            acc(1'b0, IDX[i], 8'h02, 32'h0);
            check(32'({ack_seen, err_seen}), 32'h2);
            check(obj_rdata, {16'h0000, RA[i]});
        end
    endtask
    // Upper bits set on purpose: they must change nothing
    task t_run;
        for (int s = 0; s < 4; s++) begin
            run_command_source = s[1:0];
            acc(1'b1, 16'h2000, 8'h01, 32'h0000_ffff);
            wait_cyc(2 * TK);
            check(32'(run_forward), 32'(s == 3));
            check(32'(run_reverse), 32'(s == 3));
            check(32'(input_terminal), 32'h3f);
            check(32'(network_external_fault), 32'h1);
            check(32'(fault_reset), 32'h1);
        end
        acc(1'b1, 16'h2000, 8'h01, 32'h0000_fd55);
        wait_cyc(2 * TK);
        check(32'({run_reverse, run_forward}), 32'h1);
        check(32'(input_terminal), 32'h15);
        check(32'({fault_reset, network_external_fault}), 32'h1);
    endtask
    task t_setpoints;
        acc(1'b1, 16'h2010, 8'h01, 32'h0000_1234);
        acc(1'b1, 16'h2020, 8'h01, 32'h0000_0321);
        acc(1'b1, 16'h2030, 8'h01, 32'h0000_0055);
        wait_cyc(2 * TK);
        check(32'(torque_compensation_out), 32'h55);
        for (int c = 0; c < 2; c++) begin
            for (int t = 0; t < 4; t++) begin
                control_selection = c[0];
                torque_reference_source = t[1:0];
                speed_display_unit = t[1:0];
                wait_cyc(1);
                check(32'(speed_reference), c == 0 ? 32'h1234 : 32'h0);
                check(32'(speed_limit), c == 1 ? 32'h1234 : 32'h0);
                check(32'(speed_unit), 32'(t));
                check(32'(torque_valid), 32'(t == 1));
                check(32'(torque_reference),
                      (t == 1 && c == 1) ? 32'h321 : 32'h0);
                check(32'(torque_limit),
                      (t == 1 && c == 0) ? 32'h321 : 32'h0);
            end
        end
    endtask
    // Slow drive answers while both indirect requests are pending
    task t_drive;
        ack_delay = 4'h3;
        acc(1'b1, 16'h2040, 8'h01, 32'h0010_0000);
        acc(1'b1, 16'h2050, 8'h01, 32'h0020_abcd);
        wait_cyc(8 * TK);
        acc(1'b0, 16'h2140, 8'h01, 32'h0);
        check(obj_rdata, 32'h0000_5a10);
        acc(1'b0, 16'h2150, 8'h01, 32'h0);
        check(obj_rdata, 32'h0020_abcd);
        check(32'(u_dcom_drive_model.mem[8'h20]), 32'habcd);
        check(32'(u_dcom_drive_model.mem[8'h01]), 32'hfd55);
        check(32'(u_dcom_drive_model.mem[8'h02]), 32'h1234);
        check(32'(u_dcom_drive_model.mem[8'h04]), 32'h0321);
        check(32'(u_dcom_drive_model.mem[8'h05]), 32'h0055);
    endtask
    // Response objects and address entries are read-only
    task t_refuse;
        acc(1'b1, 16'h2140, 8'h01, 32'h0000_0001);
        check(32'({ack_seen, err_seen}), 32'h3);
        acc(1'b1, 16'h2150, 8'h01, 32'h0000_0001);
        check(32'({ack_seen, err_seen}), 32'h3);
        acc(1'b1, 16'h2010, 8'h02, 32'h0000_7777);
        check(32'({ack_seen, err_seen}), 32'h2);
        acc(1'b0, 16'h2010, 8'h02, 32'h0);
        check(obj_rdata, 32'h0000_0002);
        acc(1'b0, 16'h2010, 8'h01, 32'h0);
        check(obj_rdata, 32'h0000_1234);
        acc(1'b0, 16'h2140, 8'h01, 32'h0);
        check(obj_rdata, 32'h0000_5a10);
    endtask
    // ==========================================
    // Main sequence and watchdog
    initial begin
        repeat (6) @(posedge sys_clk);
        #1;
        resetn = 1'b1;
        t_addr();
        t_run();
        t_setpoints();
        t_drive();
        t_refuse();
        summarize();
    end
    initial begin
        #(3000 * 100);
        fails++;
        summarize();
    end
endmodule
